// ===== design/rxm_alarm_latch.sv
// one channel's pair of latched receive-power alarms (high and low).
// assumes the condition inputs are synchronous and only meaningful on
// the monitoring update pulse.

`timescale 1ns/1ps
`default_nettype none

module rxm_alarm_latch (
  input wire logic clock,
  input wire logic reset,
  input wire logic update,          // monitoring update pulse
  input wire logic cond_high,       // high power condition present
  input wire logic cond_low,        // low power condition present
  input wire logic clear,           // host read of the byte holding this pair
  output logic latched_high,
  output logic latched_low
);

  // ----------------------------------------------------------------------
  // latch state
  // ----------------------------------------------------------------------
  logic [1:0] flags;       // {high, low}
  logic [1:0] next_flags;
  logic [1:0] set_now;     // conditions seen on this update

  // set wins over clear so an event in the read cycle survives
  always_comb begin
    set_now = {cond_high, cond_low} & {2{update}};                 // [RULE11]
    next_flags = flags;
    if (clear) begin
      next_flags = 2'b00;                                          // [RULE1]
    end
    next_flags = next_flags | set_now;                             // [RULE1]
  end

  // register only
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      flags <= rxm_pkg::ALARM_RESET;
    end else begin
      flags <= next_flags;
    end
  end

  assign latched_high = flags[1];
  assign latched_low = flags[0];

endmodule : rxm_alarm_latch

`default_nettype wire

// ===== design/rxm_monitor_regs.sv
// receive monitor byte map behind an avalon-mm slave with waitrequest.
// assumes a 125 MHz clock, monitor values and alarm conditions that are
// synchronous and qualified by a one-cycle sample_valid pulse.
//
// Notes on behaviour
// RULE1 - alarm bits latch at one, clear on read
// RULE2 - byte 26 holds channel 3 and 2 flags
// RULE3 - byte 27 holds channel 1 and 0 flags
// RULE4 - bytes 30 and 31 always read zero
// RULE5 - byte 28 is signed integer temperature
// RULE6 - byte 29 is temperature fraction, 1/256 steps
// RULE7 - bytes 32-33 supply, 100 uV, msb first
// RULE8 - channel 11 power at 64, msb first
// RULE9 - channel 10 power at 66, msb first
// RULE10 - byte 25 low bits reserved, map read-only
// RULE11 - persisting alarm sets again next update
// RULE12 - both bytes of a word from one sample
//
// Chosen here: the Avalon-MM register port.

`timescale 1ns/1ps
`default_nettype none

module rxm_monitor_regs #(
  parameter int unsigned ALARM_CH = rxm_pkg::ALARM_CH
) (
  input wire logic clock,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [rxm_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [rxm_pkg::DATA_W-1:0] writedata,
  output logic [rxm_pkg::DATA_W-1:0] readdata,
  output logic waitrequest,
  // monitor side
  input wire logic sample_valid,
  input wire logic [15:0] temperature_in,
  input wire logic [15:0] supply_3v3_in,
  input wire logic [15:0] optical_power_ch11_in,
  input wire logic [15:0] optical_power_ch10_in,
  input wire logic [ALARM_CH-1:0] alarm_high_cond,
  input wire logic [ALARM_CH-1:0] alarm_low_cond
);

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  logic [rxm_pkg::INDEX_W-1:0] index;        // register index from byte address
  logic access;                              // a request is on the bus
  logic ack;                                 // answer cycle, waitrequest low
  logic next_ack;
  logic take_read;                           // edge at which the byte is fetched
  logic [rxm_pkg::DATA_W-1:0] next_readdata;
  logic [7:0] byte_value;                    // selected map byte

  // held monitor samples
  logic [15:0] temperature;
  logic [15:0] supply_3v3;
  logic [15:0] power_ch11;
  logic [15:0] power_ch10;
  logic [15:0] next_temperature;
  logic [15:0] next_supply_3v3;
  logic [15:0] next_power_ch11;
  logic [15:0] next_power_ch10;

  // low-byte snapshot for coherent pairs
  logic [7:0] snap_low;                      // low byte frozen at msb read
  logic [7:0] snap_index;                    // index of that low byte
  logic snap_valid;                          // snapshot belongs to next read
  logic [7:0] next_snap_low;
  logic [7:0] next_snap_index;
  logic next_snap_valid;

  // alarm latches
  logic [ALARM_CH-1:0] alarm_high;
  logic [ALARM_CH-1:0] alarm_low;
  logic [ALARM_CH-1:0] alarm_clear;
  logic [7:0] alarm_byte_a;
  logic [7:0] alarm_byte_b;
  logic [7:0] alarm_byte_c;

  // writedata is accepted and dropped: every byte here is read-only
  logic unused_write;

  // ----------------------------------------------------------------------
  // bus handshake
  // ----------------------------------------------------------------------
  // every access costs one wait cycle, so waitrequest is low in the second
  // cycle of a request; read data are already registered by then
  assign index = address[rxm_pkg::ADDR_W-1:2];
  assign access = read | write;
  assign waitrequest = access & ~ack;
  assign take_read = read & ~ack;
  assign unused_write = ^writedata;

  // ack for one cycle after a request was seen
  always_comb begin
    next_ack = access & ~ack;
  end

  // register only
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ack <= 1'b0;
    end else begin
      ack <= next_ack;
    end
  end

  // ----------------------------------------------------------------------
  // monitor sampling
  // ----------------------------------------------------------------------
  // all readings move together on one sample pulse, so bytes of one
  // quantity never mix two conversions between pulses
  always_comb begin
    next_temperature = temperature;
    next_supply_3v3 = supply_3v3;
    next_power_ch11 = power_ch11;
    next_power_ch10 = power_ch10;
    if (sample_valid) begin
      next_temperature = temperature_in;                           // [RULE12]
      next_supply_3v3 = supply_3v3_in;
      next_power_ch11 = optical_power_ch11_in;
      next_power_ch10 = optical_power_ch10_in;
    end
  end

  // register only
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      temperature <= rxm_pkg::MONITOR_RESET;
      supply_3v3 <= rxm_pkg::MONITOR_RESET;
      power_ch11 <= rxm_pkg::MONITOR_RESET;
      power_ch10 <= rxm_pkg::MONITOR_RESET;
    end else begin
      temperature <= next_temperature;
      supply_3v3 <= next_supply_3v3;
      power_ch11 <= next_power_ch11;
      power_ch10 <= next_power_ch10;
    end
  end

  // ----------------------------------------------------------------------
  // alarm latches, one pair per channel
  // ----------------------------------------------------------------------
  // clear goes to a pair when its byte is fetched; even channel in the
  // low nibble, odd channel in the high nibble of the same byte
  always_comb begin
    alarm_clear = '0;
    for (int c = 0; c < int'(ALARM_CH); c++) begin
      if (take_read && index == 8'(int'(rxm_pkg::IDX_RX_POWER_ALARM_BYTE_C) - c / 2)) begin
        alarm_clear[c] = 1'b1;                                     // [RULE1]
      end
    end
  end

  for (genvar g = 0; g < ALARM_CH; g++) begin : g_alarm
    rxm_alarm_latch u_latch (
      .clock(clock),
      .reset(reset),
      .update(sample_valid),
      .cond_high(alarm_high_cond[g]),
      .cond_low(alarm_low_cond[g]),
      .clear(alarm_clear[g]),
      .latched_high(alarm_high[g]),
      .latched_low(alarm_low[g])
    );
  end

  // ----------------------------------------------------------------------
  // alarm byte packing
  // ----------------------------------------------------------------------
  // reserved bits 5-4 and 1-0 are constant zero
  // limitation: the map has room for six channels only, so ALARM_CH
  // must stay at six; a smaller value would index past the latch
  // vectors and a larger one has no byte to land in
  always_comb begin
    alarm_byte_a = rxm_pkg::RESERVED_VALUE;
    alarm_byte_b = rxm_pkg::RESERVED_VALUE;
    alarm_byte_c = rxm_pkg::RESERVED_VALUE;
    alarm_byte_a[rxm_pkg::BIT_HIGH_ODD] = alarm_high[5];
    alarm_byte_a[rxm_pkg::BIT_LOW_ODD] = alarm_low[5];
    alarm_byte_a[rxm_pkg::BIT_HIGH_EVEN] = alarm_high[4];
    alarm_byte_a[rxm_pkg::BIT_LOW_EVEN] = alarm_low[4];            // [RULE10]
    alarm_byte_b[rxm_pkg::BIT_HIGH_ODD] = alarm_high[3];           // [RULE2]
    alarm_byte_b[rxm_pkg::BIT_LOW_ODD] = alarm_low[3];             // [RULE2]
    alarm_byte_b[rxm_pkg::BIT_HIGH_EVEN] = alarm_high[2];          // [RULE2]
    alarm_byte_b[rxm_pkg::BIT_LOW_EVEN] = alarm_low[2];            // [RULE2]
    alarm_byte_c[rxm_pkg::BIT_HIGH_ODD] = alarm_high[1];           // [RULE3]
    alarm_byte_c[rxm_pkg::BIT_LOW_ODD] = alarm_low[1];             // [RULE3]
    alarm_byte_c[rxm_pkg::BIT_HIGH_EVEN] = alarm_high[0];          // [RULE3]
    alarm_byte_c[rxm_pkg::BIT_LOW_EVEN] = alarm_low[0];            // [RULE3]
  end

  // ----------------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------------
  // a low byte read straight after its msb returns the frozen copy;
  // any other index, mapped or not, reads from the live map or zero
  always_comb begin
    byte_value = rxm_pkg::RESERVED_VALUE;
    case (index)
      rxm_pkg::IDX_RX_POWER_ALARM_BYTE_A: byte_value = alarm_byte_a;
      rxm_pkg::IDX_RX_POWER_ALARM_BYTE_B: byte_value = alarm_byte_b;
      rxm_pkg::IDX_RX_POWER_ALARM_BYTE_C: byte_value = alarm_byte_c;
      rxm_pkg::IDX_TEMPERATURE_INTEGER: byte_value = temperature[15:8];    // [RULE5]
      rxm_pkg::IDX_TEMPERATURE_FRACTION: byte_value = temperature[7:0];    // [RULE6]
      rxm_pkg::IDX_RESERVED_ZERO_HI: byte_value = rxm_pkg::RESERVED_VALUE; // [RULE4]
      rxm_pkg::IDX_RESERVED_ZERO_LO: byte_value = rxm_pkg::RESERVED_VALUE; // [RULE4]
      rxm_pkg::IDX_SUPPLY_3V3_MSB: byte_value = supply_3v3[15:8];          // [RULE7]
      rxm_pkg::IDX_SUPPLY_3V3_LSB: byte_value = supply_3v3[7:0];           // [RULE7]
      rxm_pkg::IDX_OPTICAL_POWER_CH11_MSB: byte_value = power_ch11[15:8];  // [RULE8]
      rxm_pkg::IDX_OPTICAL_POWER_CH11_LSB: byte_value = power_ch11[7:0];   // [RULE8]
      rxm_pkg::IDX_OPTICAL_POWER_CH10_MSB: byte_value = power_ch10[15:8];  // [RULE9]
      rxm_pkg::IDX_OPTICAL_POWER_CH10_LSB: byte_value = power_ch10[7:0];   // [RULE9]
      default: byte_value = rxm_pkg::RESERVED_VALUE;
    endcase
    if (snap_valid && index == snap_index) begin
      byte_value = snap_low;                                       // [RULE12]
    end
  end

  // read data held until the next read is fetched
  always_comb begin
    next_readdata = readdata;
    if (take_read) begin
      next_readdata = {24'h00_0000, byte_value};
    end
  end

  // register only
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      readdata <= rxm_pkg::READDATA_RESET;
    end else begin
      readdata <= next_readdata;
    end
  end

  // ----------------------------------------------------------------------
  // coherent pair snapshot
  // ----------------------------------------------------------------------
  // reading the msb of a 16-bit quantity freezes its low byte; the copy
  // serves only the very next read, so a host that skips the low byte
  // simply gets a fresh pair next time
  always_comb begin
    next_snap_low = snap_low;
    next_snap_index = snap_index;
    next_snap_valid = snap_valid;
    if (take_read) begin
      next_snap_valid = 1'b0;
      case (index)
        rxm_pkg::IDX_TEMPERATURE_INTEGER: begin
          next_snap_low = temperature[7:0];                        // [RULE12]
          next_snap_index = rxm_pkg::IDX_TEMPERATURE_FRACTION;
          next_snap_valid = 1'b1;
        end
        rxm_pkg::IDX_SUPPLY_3V3_MSB: begin
          next_snap_low = supply_3v3[7:0];                         // [RULE12]
          next_snap_index = rxm_pkg::IDX_SUPPLY_3V3_LSB;
          next_snap_valid = 1'b1;
        end
        rxm_pkg::IDX_OPTICAL_POWER_CH11_MSB: begin
          next_snap_low = power_ch11[7:0];                         // [RULE12]
          next_snap_index = rxm_pkg::IDX_OPTICAL_POWER_CH11_LSB;
          next_snap_valid = 1'b1;
        end
        rxm_pkg::IDX_OPTICAL_POWER_CH10_MSB: begin
          next_snap_low = power_ch10[7:0];                         // [RULE12]
          next_snap_index = rxm_pkg::IDX_OPTICAL_POWER_CH10_LSB;
          next_snap_valid = 1'b1;
        end
        default: begin
          next_snap_valid = 1'b0;
        end
      endcase
    end
  end

  // register only
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      snap_low <= rxm_pkg::RESERVED_VALUE;
      snap_index <= rxm_pkg::RESERVED_VALUE;
      snap_valid <= 1'b0;
    end else begin
      snap_low <= next_snap_low;
      snap_index <= next_snap_index;
      snap_valid <= next_snap_valid;
    end
  end

  // ----------------------------------------------------------------------
  // writes
  // ----------------------------------------------------------------------
  // writes get the normal one-wait answer and change nothing, so a stray
  // write can neither clear an alarm nor disturb a reading [RULE10]
  // the price is that a host gets no error for a write; it must know
  // the map is read-only, and writedata only feeds the unused_write sink
  // hazard avoided: a misdirected host write can never silently turn
  // off alarm reporting or freeze a reading

endmodule : rxm_monitor_regs

`default_nettype wire

// ===== design/rxm_pkg.sv
// package for the receive monitor byte map: register indices, alarm bit
// positions, reset values and bus widths.
// assumes a byte-wide map reached one byte per 32-bit bus word.

package rxm_pkg;

  // ----------------------------------------------------------------------
  // bus geometry
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W = 10;            // byte address width
  localparam int unsigned DATA_W = 32;            // avalon data width
  localparam int unsigned INDEX_W = 8;            // register index width
  localparam int unsigned BYTE_W = 8;             // width of one map byte
  localparam int unsigned ALARM_CH = 6;           // channels 0..5 latched here

  // ----------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ----------------------------------------------------------------------
  localparam logic [7:0] IDX_RX_POWER_ALARM_BYTE_A = 8'h19;  // ch5, ch4
  localparam logic [7:0] IDX_RX_POWER_ALARM_BYTE_B = 8'h1a;  // ch3, ch2
  localparam logic [7:0] IDX_RX_POWER_ALARM_BYTE_C = 8'h1b;  // ch1, ch0
  localparam logic [7:0] IDX_TEMPERATURE_INTEGER = 8'h1c;
  localparam logic [7:0] IDX_TEMPERATURE_FRACTION = 8'h1d;
  localparam logic [7:0] IDX_RESERVED_ZERO_HI = 8'h1e;
  localparam logic [7:0] IDX_RESERVED_ZERO_LO = 8'h1f;
  localparam logic [7:0] IDX_SUPPLY_3V3_MSB = 8'h20;
  localparam logic [7:0] IDX_SUPPLY_3V3_LSB = 8'h21;
  localparam logic [7:0] IDX_OPTICAL_POWER_CH11_MSB = 8'h40;
  localparam logic [7:0] IDX_OPTICAL_POWER_CH11_LSB = 8'h41;
  localparam logic [7:0] IDX_OPTICAL_POWER_CH10_MSB = 8'h42;
  localparam logic [7:0] IDX_OPTICAL_POWER_CH10_LSB = 8'h43;

  // ----------------------------------------------------------------------
  // alarm byte field positions: odd channel in the top nibble
  // ----------------------------------------------------------------------
  localparam int unsigned BIT_HIGH_ODD = 7;
  localparam int unsigned BIT_LOW_ODD = 6;
  localparam int unsigned BIT_HIGH_EVEN = 3;
  localparam int unsigned BIT_LOW_EVEN = 2;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] RESERVED_VALUE = 8'h00;        // reserved bytes read zero
  localparam logic [15:0] MONITOR_RESET = 16'h0000;     // readings before first sample
  localparam logic [1:0] ALARM_RESET = 2'b00;           // no alarm latched
  localparam logic [31:0] READDATA_RESET = 32'h0000_0000;

endpackage : rxm_pkg

// ===== dv/rxm_host_model.sv
// host model: avalon-mm master that reads and writes monitor bytes.
// assumes one clock shared with the block and a bench that calls xfer.
`timescale 1ns/1ps
`default_nettype none
module rxm_host_model (
  input wire logic clock,
  output logic [rxm_pkg::ADDR_W-1:0] address,
  output logic read,
  output logic write,
  output logic [rxm_pkg::DATA_W-1:0] writedata,
  input wire logic [rxm_pkg::DATA_W-1:0] readdata,
  input wire logic waitrequest
);
  // -----------------------------------------
  // idle bus at time zero
  // -----------------------------------------
  initial begin
    {address, read, write, writedata} = '0;
  end
  // -----------------------------------------
  // one transfer, held until waitrequest low
  // -----------------------------------------
  task automatic xfer(input logic wr, input logic [7:0] idx,
                      input logic [31:0] wd, output logic [31:0] rdat);
    @(posedge clock);
    read <= !wr;
    write <= wr;
    address <= {idx, 2'b00};
    writedata <= wd;
    @(posedge clock);
    while (waitrequest) @(posedge clock);
    rdat = readdata; // taken at the answer edge
    {read, write} <= 2'b00;
    // released lines change so stale values never look valid
    address <= ~address;
    writedata <= ~writedata;
  endtask : xfer
endmodule : rxm_host_model
`default_nettype wire

// ===== dv/rxm_monitor_regs_properties.sv
// checker for the receive monitor byte map.
// assumes it is bound to rxm_monitor_regs and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module rxm_monitor_regs_properties #(
  parameter int unsigned ALARM_CH = 6
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic sample_valid,
  input wire logic [15:0] temperature_in,
  input wire logic [15:0] supply_3v3_in,
  input wire logic [15:0] optical_power_ch11_in,
  input wire logic [15:0] optical_power_ch10_in,
  input wire logic [ALARM_CH-1:0] alarm_high_cond,
  input wire logic [ALARM_CH-1:0] alarm_low_cond
);
  // -----------------------------------------
  // fetch decode and shadow of the last sample
  // -----------------------------------------
  logic fetch; // first cycle of a read
  logic [7:0] idx; // register index
  logic [7:0] tint_q, sup_q, p11h_q, p11l_q, p10h_q;
  assign fetch = read && waitrequest;
  assign idx = address[9:2];
  // shadow follows the block's sample strobe only
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      {tint_q, sup_q, p11h_q, p11l_q, p10h_q} <= '0;
    end else if (sample_valid) begin
      {tint_q, sup_q, p11h_q, p11l_q, p10h_q} <= {temperature_in[15:8],
        supply_3v3_in[15:8], optical_power_ch11_in, optical_power_ch10_in[15:8]};
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  // -----------------------------------------
  // assertions
  // -----------------------------------------
  a_clear_on_read: assert property (fetch && idx == 8'h1b && !sample_valid ##1 !sample_valid[*2]
    ##1 fetch && idx == 8'h1b |=> readdata == 32'h0000_0000) else $error("alarm byte not cleared by read");
  a_ch2_high_set: assert property (sample_valid && alarm_high_cond[2] ##1 !read[*3]
    ##1 fetch && idx == 8'h1a |=> readdata[3]) else $error("ch2 high alarm not latched");
  a_ch0_low_set: assert property (sample_valid && alarm_low_cond[0] ##1 !read[*3]
    ##1 fetch && idx == 8'h1b |=> readdata[2]) else $error("ch0 low alarm not latched");
  a_alarm_rsvd_bits: assert property (fetch && idx inside {8'h19, 8'h1a, 8'h1b}
    |=> readdata[5:4] == 2'b00 && readdata[1:0] == 2'b00) else $error("alarm reserved bits set");
  a_rsvd_pair_zero: assert property (fetch && idx inside {8'h1e, 8'h1f}
    |=> readdata == 32'h0000_0000) else $error("reserved byte not zero");
  a_temp_int_byte: assert property (fetch && idx == 8'h1c
    |=> readdata[7:0] == $past(tint_q)) else $error("temperature integer byte wrong");
  a_supply_msb: assert property (fetch && idx == 8'h20
    |=> readdata[7:0] == $past(sup_q)) else $error("supply msb wrong");
  a_ch11_msb: assert property (fetch && idx == 8'h40
    |=> readdata[7:0] == $past(p11h_q)) else $error("ch11 msb wrong");
  a_ch10_msb: assert property (fetch && idx == 8'h42
    |=> readdata[7:0] == $past(p10h_q)) else $error("ch10 msb wrong");
  a_ch11_snapshot: assert property (fetch && idx == 8'h40 ##3 fetch && idx == 8'h41
    |=> readdata[7:0] == $past(p11l_q, 4)) else $error("ch11 low byte not from same sample");
  a_write_ignored: assert property (write && waitrequest
    |=> !waitrequest && $stable(readdata)) else $error("write changed read data");
  // -----------------------------------------
  // covers
  // -----------------------------------------
  c_alarm_read: cover property (fetch && idx == 8'h1b);
  c_snapshot: cover property (fetch && idx == 8'h40 ##3 fetch && idx == 8'h41);
  c_write: cover property (write && waitrequest);
endmodule : rxm_monitor_regs_properties
bind rxm_monitor_regs rxm_monitor_regs_properties #(.ALARM_CH(ALARM_CH)) rxm_monitor_regs_properties_inst (
  .clock(clock), .reset(reset), .address(address), .read(read), .write(write), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .sample_valid(sample_valid),
  .temperature_in(temperature_in), .supply_3v3_in(supply_3v3_in),
  .optical_power_ch11_in(optical_power_ch11_in), .optical_power_ch10_in(optical_power_ch10_in),
  .alarm_high_cond(alarm_high_cond), .alarm_low_cond(alarm_low_cond));
`default_nettype wire

// ===== dv/rxm_monitor_regs_test.sv
// self-checking bench for the receive monitor byte map.
// assumes the host model drives the bus and this bench the monitor side.
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("wrong value %s expected %h seen %h", nm, e, g); end end
module rxm_monitor_regs_test;
  // -----------------------------------------
  // signals
  // -----------------------------------------
  logic clock = 1'b0;
  logic reset, sample_valid, read, write, waitrequest;
  logic [9:0] address;
  logic [31:0] writedata, readdata, got;
  logic [15:0] t_in, s_in, p11_in, p10_in; // monitor readings
  logic [5:0] hi_c, lo_c; // alarm conditions
  int error_cnt = 0;
  int check_count = 0;
  always #4 clock = ~clock; // 125 MHz
  rxm_monitor_regs rxm_monitor_regs_inst (.clock(clock), .reset(reset), .address(address),
    .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .sample_valid(sample_valid), .temperature_in(t_in),
    .supply_3v3_in(s_in), .optical_power_ch11_in(p11_in), .optical_power_ch10_in(p10_in),
    .alarm_high_cond(hi_c), .alarm_low_cond(lo_c));
  rxm_host_model rxm_host_model_inst (.clock(clock), .address(address), .read(read),
    .write(write), .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest));
  // -----------------------------------------
  // helpers
  // -----------------------------------------
  // one sample strobe with new readings and conditions
  task automatic smp(input logic [15:0] t, s, a, b, input logic [5:0] h, l);
    @(posedge clock);
    sample_valid <= 1'b1;
    {t_in, s_in, p11_in, p10_in, hi_c, lo_c} <= {t, s, a, b, h, l};
    @(posedge clock);
    sample_valid <= 1'b0;
  endtask : smp
  // read one byte and compare the whole word
  task automatic rdc(input logic [7:0] i, input logic [7:0] e);
    rxm_host_model_inst.xfer(1'b0, i, 32'h0000_0000, got);
    `CHK($sformatf("byte %h", i), {24'h00_0000, e}, got)
  endtask : rdc
  task automatic report_and_stop();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : report_and_stop
  // -----------------------------------------
  // scenarios
  // -----------------------------------------
  // everything reads zero before the first sample
  task automatic t_reset_map();
    logic [7:0] tbl [13] = '{8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1e, 8'h1f,
                             8'h20, 8'h21, 8'h40, 8'h41, 8'h42, 8'h43};
    foreach (tbl[k]) rdc(tbl[k], 8'h00);
  endtask : t_reset_map
  // negative temperature, msb-first words
  task automatic t_readings();
    smp(16'he780, 16'h80f5, 16'h1234, 16'hbeef, 6'h00, 6'h00);
    rdc(8'h1c, 8'he7);
    rdc(8'h1d, 8'h80);
    rdc(8'h1e, 8'h00);
    rdc(8'h1f, 8'h00);
    rdc(8'h20, 8'h80);
    rdc(8'h21, 8'hf5);
    rdc(8'h40, 8'h12);
    rdc(8'h41, 8'h34);
    rdc(8'h42, 8'hbe);
    rdc(8'h43, 8'hef);
  endtask : t_readings
  // new sample between msb and lsb must not tear the word
  task automatic t_coherent();
    rdc(8'h40, 8'h12);
    smp(16'he780, 16'h80f5, 16'h5678, 16'hbeef, 6'h00, 6'h00);
    rdc(8'h41, 8'h34);
    rdc(8'h41, 8'h78);
  endtask : t_coherent
  // every channel and polarity: latch, hold, clear on read
  task automatic t_alarms();
    logic [7:0] i;
    logic [7:0] m;
    for (int ch = 0; ch < 6; ch++) begin
      for (int lo = 0; lo < 2; lo++) begin
        i = 8'h1b - 8'(ch / 2);
        m = 8'h01 << ((ch % 2 == 1 ? 7 : 3) - lo);
        smp(t_in, s_in, p11_in, p10_in, lo == 1 ? 6'h00 : 6'(1 << ch), lo == 1 ? 6'(1 << ch) : 6'h00);
        smp(t_in, s_in, p11_in, p10_in, 6'h00, 6'h00); // condition gone, bit must hold
        rdc(i, m);
        rdc(i, 8'h00);
      end
    end
  endtask : t_alarms
  // a condition that persists sets the bit again
  task automatic t_persist();
    smp(t_in, s_in, p11_in, p10_in, 6'h02, 6'h00);
    rdc(8'h1b, 8'h80);
    smp(t_in, s_in, p11_in, p10_in, 6'h02, 6'h00);
    rdc(8'h1b, 8'h80);
    rdc(8'h1b, 8'h00);
  endtask : t_persist
  // writes are ignored, unmapped reads zero
  task automatic t_write();
    smp(t_in, s_in, p11_in, p10_in, 6'h00, 6'h20);
    rxm_host_model_inst.xfer(1'b1, 8'h19, 32'hffff_ffff, got);
    rdc(8'h19, 8'h40);
    rxm_host_model_inst.xfer(1'b1, 8'h1c, 32'h0000_00aa, got);
    rdc(8'h1c, 8'he7);
    rxm_host_model_inst.xfer(1'b1, 8'h1e, 32'hffff_ffff, got);
    rdc(8'h1e, 8'h00);
    rdc(8'h3f, 8'h00);
  endtask : t_write
  // -----------------------------------------
  // main sequence and watchdog
  // -----------------------------------------
  initial begin
    reset = 1'b1;
    sample_valid = 1'b0;
    {t_in, s_in, p11_in, p10_in, hi_c, lo_c} = '0;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    t_reset_map();
    t_readings();
    t_coherent();
    t_alarms();
    t_persist();
    t_write();
    report_and_stop();
  end
  // whole run is well under a thousand cycles
  initial begin
    #100000;
    error_cnt++;
    report_and_stop();
  end
endmodule : rxm_monitor_regs_test
`default_nettype wire
